// file: divided_clock_output_pkg.sv
// Constants for the start-up settle timer and the divided clock output.
// Assumes a 50 MHz system clock standing in for a 25 MHz oscillator input.
//
// Summary of operation
// - The settle timer expires only after 7500 oscillator cycles (about 300 us) following power-on reset or power-down exit.
// - While the settle timer runs, the registers stay fully readable and writable.
// - On timer expiry the clock ready flag in the global status register is set for the host to poll.
// - The select field picks divide by 1, 2, 3, 4 or 8; 000 disables and drives low; 11x is reserved.
// - The divided clock output is held low through power-on reset and the first settle count.
// - On first expiry after power-up the output starts at the default divide by four (6.25 MHz).
// - Software or pin resets leave the clock output control register and the output running unchanged.
// - The output keeps running in power-down; leaving power-down restarts the settle timer only.
// - Enabling, disabling or changing the ratio never yields a pulse shorter than the selected rate allows.
// - A ratio change inserts a low gap of eight oscillator periods with no pulses.
package divided_clock_output_pkg;

  // ------------------------------------------------------------------
  // Clock rates and timing
  // ------------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ      = 50_000_000;
  localparam int unsigned OSC_HZ          = 25_000_000;
  localparam int unsigned SYS_PER_OSC     = SYS_CLK_HZ / OSC_HZ;  // 2
  localparam int unsigned HALF_OSC_SYS    = SYS_PER_OSC / 2;      // Sys cycles per half osc period
  localparam int unsigned STARTUP_TIME_US = 300;
  localparam int unsigned STARTUP_OSC_CNT = 7500;
  localparam int unsigned STARTUP_CNT_W   = 13;
  localparam int unsigned GAP_OSC         = 8;
  localparam int unsigned GAP_SYS         = GAP_OSC * SYS_PER_OSC;
  localparam int unsigned PH_CNT_W        = 5;

  // ------------------------------------------------------------------
  // Registers and fields
  // ------------------------------------------------------------------
  localparam int unsigned  SEL_W           = 3;
  localparam logic [2:0]   CTRL_SEL_RESET  = 3'h4;  // Divide by four
  localparam int unsigned  CLOCK_READY_BIT = 0;     // In global_status_reg

  // Select codes
  localparam logic [2:0] SEL_OFF  = 3'h0;
  localparam logic [2:0] SEL_DIV1 = 3'h1;
  localparam logic [2:0] SEL_DIV2 = 3'h2;
  localparam logic [2:0] SEL_DIV3 = 3'h3;
  localparam logic [2:0] SEL_DIV4 = 3'h4;
  localparam logic [2:0] SEL_DIV8 = 3'h5;

  // Output phases, one-hot
  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_HIGH = 4'h2,
    PH_LOW  = 4'h4,
    PH_GAP  = 4'h8
  } phase_t;

  // High length in sys cycles; zero marks off or reserved
  function automatic logic [PH_CNT_W-1:0] high_len(input logic [2:0] sel);
    int unsigned n;
    n = 0;
    case (sel)
      SEL_DIV1: n = 1 * HALF_OSC_SYS;
      SEL_DIV2: n = 2 * HALF_OSC_SYS;
      SEL_DIV3: n = 2 * HALF_OSC_SYS;  // One main clock period
      SEL_DIV4: n = 4 * HALF_OSC_SYS;
      SEL_DIV8: n = 8 * HALF_OSC_SYS;
      default:  n = 0;
    endcase
    return n[PH_CNT_W-1:0];
  endfunction

  // Low length in sys cycles
  function automatic logic [PH_CNT_W-1:0] low_len(input logic [2:0] sel);
    int unsigned n;
    n = 0;
    case (sel)
      SEL_DIV1: n = 1 * HALF_OSC_SYS;
      SEL_DIV2: n = 2 * HALF_OSC_SYS;
      SEL_DIV3: n = 4 * HALF_OSC_SYS;  // Two main clock periods
      SEL_DIV4: n = 4 * HALF_OSC_SYS;
      SEL_DIV8: n = 8 * HALF_OSC_SYS;
      default:  n = 0;
    endcase
    return n[PH_CNT_W-1:0];
  endfunction

endpackage

// file: divided_clock_output_divider.sv
// Glitch-free programmable divider driving the divided clock output.
// Assumes sel may change at any cycle; run rises once and stays high.
`timescale 1ns/10ps
`default_nettype none
module divided_clock_output_divider
  import divided_clock_output_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic [SEL_W-1:0] sel,
  output var  logic             clk_out
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    phase_t              phase;
    logic [PH_CNT_W-1:0] cnt;
    logic [SEL_W-1:0]    active;
    logic                out;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;

  // Next state; ratio changes only take effect at phase ends
  always_comb begin
    st_nxt = st_r;
    case (st_r.phase)
      PH_IDLE: begin
        // Idle is only left after a long low stretch, so start at once
        if (run && high_len(sel) != '0) begin
          st_nxt.phase  = PH_HIGH;
          st_nxt.active = sel;
          st_nxt.cnt    = high_len(sel) - 1'b1;
        end
      end
      PH_HIGH: begin
        if (st_r.cnt != '0) begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end else if (sel != st_r.active) begin
          st_nxt.phase = PH_GAP;
          st_nxt.cnt   = PH_CNT_W'(GAP_SYS - 1);
        end else begin
          st_nxt.phase = PH_LOW;
          st_nxt.cnt   = low_len(st_r.active) - 1'b1;
        end
      end
      PH_LOW: begin
        if (st_r.cnt != '0) begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end else if (sel != st_r.active) begin
          st_nxt.phase = PH_GAP;
          st_nxt.cnt   = PH_CNT_W'(GAP_SYS - 1);
        end else begin
          st_nxt.phase = PH_HIGH;
          st_nxt.cnt   = high_len(st_r.active) - 1'b1;
        end
      end
      PH_GAP: begin
        if (st_r.cnt != '0) begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end else if (high_len(sel) == '0) begin  // off or reserved
          st_nxt.phase = PH_IDLE;
        end else begin
          st_nxt.phase  = PH_HIGH;
          st_nxt.active = sel;
          st_nxt.cnt    = high_len(sel) - 1'b1;
        end
      end
      default: begin
        st_nxt.phase = PH_IDLE;
        st_nxt.cnt   = '0;
      end
    endcase
    st_nxt.out = (st_nxt.phase == PH_HIGH);  // Low in idle and gap
  end

  // Registered output keeps the pin free of decode glitches
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '{phase: PH_IDLE, cnt: '0, active: SEL_OFF, out: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clk_out = st_r.out;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic [PH_CNT_W-1:0] hrun_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrun_r <= '0;
    end else begin
      hrun_r <= clk_out ? hrun_r + 1'b1 : '0;
    end
  end

  property p_high_len;
    @(posedge sys_clk) disable iff (rst)
      $fell(clk_out) |-> hrun_r == high_len(st_r.active);
  endproperty
  a_high_len: assert property (p_high_len) else $error("High pulse length wrong");

  property p_gap_low;
    @(posedge sys_clk) disable iff (rst)
      (st_r.phase == PH_GAP) && !$past(st_r.phase == PH_GAP) |-> !clk_out [*8] ##1 !clk_out [*8];
  endproperty
  a_gap_low: assert property (p_gap_low) else $error("Gap not held low");

  property p_div3_shape;
    @(posedge sys_clk) disable iff (rst)
      $rose(clk_out) && st_r.active == SEL_DIV3 && sel == SEL_DIV3 |-> clk_out [*2] ##1 !clk_out [*4];
  endproperty
  a_div3_shape: assert property (p_div3_shape) else $error("Divide by three shape wrong");

  property p_div8_shape;
    @(posedge sys_clk) disable iff (rst)
      $rose(clk_out) && st_r.active == SEL_DIV8 |-> clk_out [*8] ##1 !clk_out [*8];
  endproperty
  a_div8_shape: assert property (p_div8_shape) else $error("Divide by eight shape wrong");

endmodule
`default_nettype wire

// file: startup_clock_ctrl.sv
// Start-up settle timer, clock ready status and clock output control.
// The control register is reached through dedicated write and read ports.
// Assumes rst is the power-on reset; power_down is a synchronous level.
// Assumes soft and pin resets are applied elsewhere and never reach here.
// Assumes two sys_clk cycles per oscillator period.
`timescale 1ns/10ps
`default_nettype none
module startup_clock_ctrl
  import divided_clock_output_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_OSC_CNT
)(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       power_down,
  input  wire logic       ctrl_wr_en,
  input  wire logic [7:0] ctrl_wdata,
  output var  logic [7:0] ctrl_rdata,
  output var  logic [7:0] status_rdata,
  output var  logic       clock_ready_flag,
  output var  logic       divided_clock_output
);

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  if (STARTUP_CYCLES < 2 || STARTUP_CYCLES > (2 ** STARTUP_CNT_W) - 1) begin : g_bad_count
    $error("STARTUP_CYCLES out of counter range");
  end

  localparam logic [STARTUP_CNT_W-1:0] LAST_CNT = STARTUP_CNT_W'(STARTUP_CYCLES - 1);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                     osc_tick;  // Toggles each cycle: one osc period per two
    logic [STARTUP_CNT_W-1:0] cnt;
    logic                     ready;
    logic                     started;   // Output released after first expiry
    logic [SEL_W-1:0]         out_sel;   // Clock output select field
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;

  // Settle timer, status and register write
  always_comb begin
    st_nxt          = st_r;
    st_nxt.osc_tick = ~st_r.osc_tick;
    if (power_down) begin
      // Timer restarts from zero once power-down ends; output keeps running
      st_nxt.cnt      = '0;
      st_nxt.ready    = 1'b0;
      st_nxt.osc_tick = 1'b0;
    end else if (!st_r.ready && st_r.osc_tick) begin
      if (st_r.cnt == LAST_CNT) begin
        st_nxt.ready   = 1'b1;
        st_nxt.started = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
    // Writes are open while the timer runs; high bits are dropped
    // Reserved codes are stored as written, the divider treats them as off
    if (ctrl_wr_en) begin
      st_nxt.out_sel = ctrl_wdata[SEL_W-1:0];
    end
  end

  // Only power-on reset touches the control register, never a soft reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '{osc_tick: 1'b0, cnt: '0, ready: 1'b0, started: 1'b0, out_sel: CTRL_SEL_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Register read and status
  // ------------------------------------------------------------------
  // Unimplemented high bits read as zero
  always_comb begin
    ctrl_rdata                   = '0;
    ctrl_rdata[SEL_W-1:0]        = st_r.out_sel;
    status_rdata                 = '0;
    status_rdata[CLOCK_READY_BIT] = st_r.ready;
  end

  assign clock_ready_flag = st_r.ready;

  // ------------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------------
  // Held low until first expiry, then free of the timer for good
  divided_clock_output_divider u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (st_r.started),
    .sel     (st_r.out_sel),
    .clk_out (divided_clock_output)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  int unsigned since_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      since_r <= 0;
    end else begin
      since_r <= power_down ? 0 : since_r + 1;
    end
  end

  property p_min_settle;
    @(posedge sys_clk) disable iff (rst)
      $rose(clock_ready_flag) |-> since_r >= 2 * STARTUP_CYCLES - 1;
  endproperty
  a_min_settle: assert property (p_min_settle) else $error("Ready too early");

  property p_ready_hold;
    @(posedge sys_clk) disable iff (rst)
      clock_ready_flag && !power_down |=> clock_ready_flag && status_rdata[CLOCK_READY_BIT];
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("Ready dropped");

  property p_write_early;
    @(posedge sys_clk) disable iff (rst)
      ctrl_wr_en && !clock_ready_flag |=> ctrl_rdata == {5'h00, $past(ctrl_wdata[2:0])};
  endproperty
  a_write_early: assert property (p_write_early) else $error("Write lost before ready");

  property p_low_before_start;
    @(posedge sys_clk) disable iff (rst)
      !st_r.started |-> !divided_clock_output;
  endproperty
  a_low_before_start: assert property (p_low_before_start) else $error("Output active too soon");

  property p_default_div4;
    @(posedge sys_clk) disable iff (rst)
      $rose(st_r.started) && st_r.out_sel == SEL_DIV4 && !ctrl_wr_en
        |=> divided_clock_output [*4] ##1 !divided_clock_output [*4];
  endproperty
  a_default_div4: assert property (p_default_div4) else $error("Default rate wrong");

  property p_ctrl_stable;
    @(posedge sys_clk) disable iff (rst)
      !ctrl_wr_en |=> $stable(ctrl_rdata);
  endproperty
  a_ctrl_stable: assert property (p_ctrl_stable) else $error("Control changed unwritten");

  property p_pd_restart;
    @(posedge sys_clk) disable iff (rst)
      $fell(power_down) |-> !clock_ready_flag ##1 (st_r.started == $past(st_r.started));
  endproperty
  a_pd_restart: assert property (p_pd_restart) else $error("Power-down exit wrong");

  // Entering power-down drops ready at once, in the flag and the status image
  property p_pd_clears_ready;
    @(posedge sys_clk) disable iff (rst)
      power_down |=> !clock_ready_flag && !status_rdata[CLOCK_READY_BIT];
  endproperty
  a_pd_clears_ready: assert property (p_pd_clears_ready) else $error("Ready kept in power-down");

  // Ready may not lag the count either, so a stuck timer is caught
  property p_ready_in_time;
    @(posedge sys_clk) disable iff (rst)
      !power_down && since_r >= 2 * STARTUP_CYCLES |-> clock_ready_flag;
  endproperty
  a_ready_in_time: assert property (p_ready_in_time) else $error("Ready too late");

  // Status image carries the ready flag and nothing else
  property p_status_image;
    @(posedge sys_clk) disable iff (rst)
      status_rdata[CLOCK_READY_BIT] == clock_ready_flag
        && $countones(status_rdata) == int'(clock_ready_flag);
  endproperty
  a_status_image: assert property (p_status_image) else $error("Status image wrong");

  // Unimplemented control bits must read as zero whatever was written
  property p_ctrl_unused_zero;
    @(posedge sys_clk) disable iff (rst)
      ctrl_rdata[7:SEL_W] == '0;
  endproperty
  a_ctrl_unused_zero: assert property (p_ctrl_unused_zero) else $error("Unused control bits set");

  // Every write lands, before ready and after it
  property p_write_lands;
    @(posedge sys_clk) disable iff (rst)
      ctrl_wr_en |=> ctrl_rdata[SEL_W-1:0] == $past(ctrl_wdata[SEL_W-1:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("Control write lost");

  // ------------------------------------------------------------------
  // Output activity watch
  // ------------------------------------------------------------------
  // Longest legal flat stretch is a full divide-by-eight low phase plus
  // the gap; anything longer with a valid select means the output stalled
  localparam logic [PH_CNT_W-1:0] FLAT_MAX = PH_CNT_W'(8 * HALF_OSC_SYS + GAP_SYS);

  logic                out_prev_r;
  logic [PH_CNT_W-1:0] flat_r;

  // Cycles the pin has kept its level; cleared while off or reserved
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_prev_r <= 1'b0;
      flat_r     <= '0;
    end else begin
      out_prev_r <= divided_clock_output;
      if (!st_r.started || high_len(st_r.out_sel) == '0 || divided_clock_output != out_prev_r) begin
        flat_r <= '0;
      end else if (flat_r != '1) begin
        flat_r <= flat_r + 1'b1;  // Saturates so it never wraps to look busy
      end
    end
  end

  // Power-down must not starve a host that runs from this output
  property p_runs_in_pd;
    @(posedge sys_clk) disable iff (rst)
      power_down |-> flat_r < FLAT_MAX;
  endproperty
  a_runs_in_pd: assert property (p_runs_in_pd) else $error("Output stalled in power-down");

endmodule
`default_nettype wire

// file: host_model.sv
// Host controller model: writes clock output control, drives power-down.
// Assumes tasks are called from the bench; pins change on falling edges.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic       sys_clk,
  input  wire logic       clock_ready_flag,
  output var  logic       ctrl_wr_en,
  output var  logic [7:0] ctrl_wdata,
  output var  logic       power_down
);
  // ------------------------------------------------------------
  // Idle state
  // ------------------------------------------------------------
  initial begin
    ctrl_wr_en  = 1'b0;
    ctrl_wdata  = 8'h00;
    power_down  = 1'b0;
  end

  // One-cycle strobe; idle cycles first model a slow host
  task automatic write_reg(input logic [7:0] d, input int idle);
    repeat (idle + 1) @(negedge sys_clk);
    ctrl_wr_en = 1'b1;
    ctrl_wdata = d;
    @(negedge sys_clk);
    ctrl_wr_en = 1'b0;
    ctrl_wdata = ~d;  // Released bus never shows stale data
  endtask

  // Power-down level, changed off the sampling edge
  task automatic set_power(input logic lvl);
    @(negedge sys_clk);
    power_down = lvl;
  endtask

  // Poll ready before normal traffic, bounded
  task automatic wait_ready(input int max, output int n);
    n = 0;
    while (clock_ready_flag !== 1'b1 && n < max) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
endmodule
`default_nettype wire

// file: tb_startup_clock_ctrl.sv
// Self-checking bench for the settle timer and divided clock output.
// Assumes a short settle count; all inputs move on falling edges.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end
module tb_startup_clock_ctrl;
  import divided_clock_output_pkg::*;
  localparam int P = 4;
  logic sys_clk, rst, pd, wr_en, rdy, pin;
  logic [7:0] wdata, ctl, stat;
  int err_count, checks_done;

  // ------------------------------------------------------------
  // Clock, design and host
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  startup_clock_ctrl #(.STARTUP_CYCLES(P)) dut (.sys_clk(sys_clk), .rst(rst),
    .power_down(pd), .ctrl_wr_en(wr_en), .ctrl_wdata(wdata), .ctrl_rdata(ctl),
    .status_rdata(stat), .clock_ready_flag(rdy), .divided_clock_output(pin));
  host_model host (.sys_clk(sys_clk), .clock_ready_flag(rdy), .ctrl_wr_en(wr_en),
    .ctrl_wdata(wdata), .power_down(pd));

  // Verdict in one place
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Bounded wait for a pin level; a hang ends the run
  task automatic wait_level(input logic lvl, input int max);
    int n;
    n = 0;
    while (pin !== lvl) begin
      @(negedge sys_clk);
      n++;
      if (n > max) begin
        err_count++;
        finish_test();
      end
    end
  endtask

  // Length of the current run at level lvl
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (pin === lvl && n < 64) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_startup();
    int n, hi, lo;
    logic seen_high;
    `CHK(pin, 1'b0)
    `CHK(ctl, 8'h04)
    rst = 1'b0;
    n = 0;
    seen_high = 1'b0;
    while (rdy !== 1'b1 && n < 40) begin
      seen_high |= (pin !== 1'b0);
      @(negedge sys_clk);
      n++;
    end
    `CHK(seen_high, 1'b0)
    `CHK(n >= 2 * P && n <= 2 * P + 1, 1'b1)
    `CHK(stat, 8'h01)
    wait_level(1'b1, 2);
    run_len(1'b1, hi);
    run_len(1'b0, lo);
    `CHK(hi, 4)
    `CHK(lo, 4)
  endtask

  // Write during power-down; pin keeps running, timer restarts
  task automatic t_power_down();
    int n, rises;
    logic prev;
    host.set_power(1'b1);
    repeat (2) @(negedge sys_clk);
    `CHK(rdy, 1'b0)
    `CHK(stat, 8'h00)
    host.write_reg(8'hfa, 0);
    `CHK(ctl, 8'h02)
    rises = 0;
    prev = pin;
    repeat (40) begin
      @(negedge sys_clk);
      if (pin === 1'b1 && prev === 1'b0) rises++;
      prev = pin;
    end
    `CHK(rises >= 4, 1'b1)
    host.set_power(1'b0);
    host.wait_ready(40, n);
    `CHK(n >= 2 * P && n <= 2 * P + 2, 1'b1)
  endtask

  // Every divide code: gap, then exact high and low lengths
  task automatic t_ratios();
    logic [2:0] sel [5] = '{SEL_DIV1, SEL_DIV2, SEL_DIV3, SEL_DIV8, SEL_DIV4};
    int hi_e [5] = '{1, 2, 2, 8, 4};
    int lo_e [5] = '{1, 2, 4, 8, 4};
    int prev_lo, g, hi, lo;
    prev_lo = 2;
    for (int i = 0; i < 5; i++) begin
      wait_level(1'b0, 40);
      wait_level(1'b1, 40);
      host.write_reg({5'h00, sel[i]}, i % 2);
      `CHK(ctl, {5'h00, sel[i]})
      wait_level(1'b0, 20);
      run_len(1'b0, g);
      run_len(1'b1, hi);
      run_len(1'b0, lo);
      `CHK(g >= 16 && g <= 16 + prev_lo, 1'b1)
      `CHK(hi, hi_e[i])
      `CHK(lo, lo_e[i])
      prev_lo = lo_e[i];
    end
  endtask

  // Off and reserved hold the pin low; enable from idle is whole
  task automatic t_off_reserved();
    int highs, hi;
    logic [7:0] code [2] = '{8'h00, 8'h06};
    for (int i = 0; i < 2; i++) begin
      host.write_reg(code[i], 0);
      `CHK(ctl, code[i])
      repeat (30) @(negedge sys_clk);
      highs = 0;
      repeat (20) begin
        @(negedge sys_clk);
        if (pin !== 1'b0) highs++;
      end
      `CHK(highs, 0)
    end
    host.write_reg(8'h04, 0);
    wait_level(1'b1, 4);
    run_len(1'b1, hi);
    `CHK(hi, 4)
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    err_count = 0;
    checks_done = 0;
    rst = 1'b1;  // Power-on only; the pin reset stays outside this block
    repeat (16) @(negedge sys_clk);
    t_startup();
    t_power_down();
    t_ratios();
    t_off_reserved();
    finish_test();
  end
endmodule
`default_nettype wire
